// >>> hw/hps_byte_tx.sv
// Purpose: Holds a captured get-status answer and hands it out byte by byte.
// Assumes: The consumer takes a byte when tx_valid and tx_ready are both high.
// Notes:   The word is frozen at load, so all bytes describe one moment.
`timescale 1ns/100ps
module hps_byte_tx
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_sync_n,
  // Load side
  input  wire logic        load,
  input  wire logic [31:0] word,
  // Byte stream
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);
  typedef struct packed {
    logic        busy;
    logic [1:0]  idx;
    logic [31:0] word;
    logic [7:0]  data;
  } hps_tx_type;

  hps_tx_type st_r;
  hps_tx_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (load)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.idx  = 2'h0;
      st_nxt.word = word;
      st_nxt.data = word[7:0];
    end
    else if (st_r.busy && tx_ready)
    begin
      st_nxt.idx  = st_r.idx + 2'h1;
      st_nxt.data = st_r.word[8*st_nxt.idx +: 8];
      if (st_r.idx == 2'(hps_pkg::DATA_BYTES - 1))
        st_nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tx_data  = st_r.data;
  assign tx_valid = st_r.busy;
endmodule // hps_byte_tx

// >>> hw/hps_pkg.sv
// Purpose: Shared constants and types of the hub port status word block.
// Assumes: One downstream port per instance, controller clock of 125 MHz.
// Notes:   Bit positions follow the port status word layout.
package hps_pkg;

  // Status word bit positions.
  localparam int unsigned BIT_CONN  = 0;
  localparam int unsigned BIT_ENA   = 1;
  localparam int unsigned BIT_SUSP  = 2;
  localparam int unsigned BIT_OC    = 3;
  localparam int unsigned BIT_RST   = 4;
  localparam int unsigned BIT_PWR   = 8;
  localparam int unsigned BIT_LOW   = 9;
  localparam int unsigned BIT_HIGH  = 10;
  localparam int unsigned BIT_TEST  = 11;
  localparam int unsigned BIT_IND   = 12;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Get-status request decode.
  localparam logic [7:0]  REQ_TYPE_PORT   = 8'hA3;
  localparam logic [7:0]  GET_STATUS_CODE = 8'h00;
  localparam logic [15:0] WVALUE_ZERO     = 16'h0000;
  localparam logic [15:0] WLENGTH_FOUR    = 16'h0004;
  localparam int unsigned DATA_BYTES      = 4;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned RESET_TIME_NS   = 10_000_000;
  localparam int unsigned RESUME_TIME_NS  = 20_000_000;
  localparam int unsigned RESET_CYC  = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESUME_CYC = (RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W      = 24;

  // Port feature selector, coded locally.
  typedef enum logic [2:0] {
    FEAT_ENABLE  = 3'h0,
    FEAT_SUSPEND = 3'h1,
    FEAT_RESET   = 3'h2,
    FEAT_POWER   = 3'h3,
    FEAT_TEST    = 3'h4,
    FEAT_IND     = 3'h5
  } hps_feat_type;

  // Port state, Gray coded along power-up, attach, reset, enable, suspend, resume.
  typedef enum logic [2:0] {
    PS_OFF     = 3'b000,
    PS_DISC    = 3'b001,
    PS_DISAB   = 3'b011,
    PS_RESET   = 3'b010,
    PS_ENA     = 3'b110,
    PS_SUSP    = 3'b111,
    PS_RESUME  = 3'b101
  } hps_port_type;

  function automatic logic is_attached(hps_port_type s);
    return (s != PS_OFF) && (s != PS_DISC);
  endfunction

  function automatic logic is_enabled(hps_port_type s);
    return (s == PS_ENA) || (s == PS_SUSP) || (s == PS_RESUME);
  endfunction

endpackage

// >>> hw/hps_port_status.sv
// Purpose: One downstream port of a hub: its state and its 16-bit status word.
// Assumes: Request and event inputs are synchronous, one-cycle strobes.
// Notes:   Reset and resume signalling are timed here by one shared counter.
`timescale 1ns/100ps
// Operation
// - Bit 0 is one while a device is attached, else zero.
// - Enable bit 1 is set only after a host-requested port reset.
// - Disconnect, port error or host disable clears the enable bit.
// - While suspended, no downstream traffic is forwarded to the port.
// - Host request or device resume signalling ends the suspend.
// - Suspend bit stays one while suspended and while resuming.
// - Bit 3 follows the per-port over-current condition.
// - Bit 4 set on host reset request until the hub ends reset signalling.
// - Reserved bits 5-7 and 13-15 always read zero.
// - Bit 8 shows logical port power; zero means powered off.
// - Bit 9 is one for an enabled low-speed device.
// - Bit 10 is one for an enabled high-speed device, bit 9 clear.
// - Bit 11 is test mode, changed only by host feature requests.
// - Bit 12 is one while software controls the indicator colour.
// - Get-status request type A3h, nonzero port, four bytes, status first.
// - Connection bit forced zero while powered off or disconnected.
module hps_port_status
#(
  parameter logic [15:0]    PORT_NUM    = 16'h0001,
  parameter bit             OC_PER_PORT = 1'b1,
  parameter int unsigned    RESET_CYC   = hps_pkg::RESET_CYC,
  parameter int unsigned    RESUME_CYC  = hps_pkg::RESUME_CYC
)
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Setup stage of a control request
  input  wire logic                 setup_valid,
  input  wire logic [7:0]           req_type,
  input  wire logic [7:0]           req_code,
  input  wire logic [15:0]          req_value,
  input  wire logic [15:0]          req_index,
  input  wire logic [15:0]          req_length,
  output logic                      req_error,
  // Port feature requests
  input  wire logic                 feat_valid,
  input  wire logic                 feat_set,
  input  wire hps_pkg::hps_feat_type feat_sel,
  // Port line events
  input  wire logic                 attach_det,
  input  wire logic                 detach_det,
  input  wire logic                 port_error,
  input  wire logic                 resume_det,
  input  wire logic                 over_current,
  input  wire logic                 dev_low_speed,
  input  wire logic                 dev_high_speed,
  // Change word supplied by the change logic
  input  wire logic [15:0]          port_change,
  // Data stage
  output logic [7:0]                tx_data,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  // Port control
  output logic [15:0]               port_status,
  output logic                      traffic_fwd,
  output logic                      reset_sig,
  output logic                      resume_sig,
  output logic                      power_on
);
  localparam int unsigned CW = hps_pkg::CNT_W;

  typedef struct packed {
    hps_pkg::hps_port_type ps;
    logic [CW-1:0]         cnt;
    logic                  low;
    logic                  high;
    logic                  test;
    logic                  ind;
    logic                  err;
  } hps_state_type;

  hps_state_type st_r;
  hps_state_type st_nxt;
  logic          rst_sync_n;
  logic          get_ok;
  logic          tx_load;
  logic [15:0]   status_w;

  hps_rst_sync u_rst
  (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .rst_sync_n (rst_sync_n)
  );

  // A get-status setup is accepted only when every field matches exactly.
  assign get_ok = (req_type == hps_pkg::REQ_TYPE_PORT)
               && (req_code == hps_pkg::GET_STATUS_CODE)
               && (req_value == hps_pkg::WVALUE_ZERO)
               && (req_length == hps_pkg::WLENGTH_FOUR)
               && (req_index != 16'h0000)
               && (req_index == PORT_NUM);
  assign tx_load = setup_valid && get_ok && !tx_valid;

  function automatic logic set_req(logic v, logic s, hps_pkg::hps_feat_type f,
                                   hps_pkg::hps_feat_type want);
    return v && s && (f == want);
  endfunction

  function automatic logic clr_req(logic v, logic s, hps_pkg::hps_feat_type f,
                                   hps_pkg::hps_feat_type want);
    return v && !s && (f == want);
  endfunction

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.err = setup_valid && !tx_load;
    if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - CW'(1);
    case (st_r.ps)
      hps_pkg::PS_OFF:
      begin
        if (set_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_POWER))
          st_nxt.ps = hps_pkg::PS_DISC;
      end
      hps_pkg::PS_DISC:
      begin
        if (attach_det)
          st_nxt.ps = hps_pkg::PS_DISAB;
      end
      hps_pkg::PS_DISAB:
      begin
        if (set_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_RESET))
        begin
          st_nxt.ps  = hps_pkg::PS_RESET;
          st_nxt.cnt = CW'(RESET_CYC - 1);
        end
      end
      hps_pkg::PS_RESET:
      begin
        if (st_r.cnt == '0)
        begin
          st_nxt.ps   = hps_pkg::PS_ENA;
          st_nxt.low  = dev_low_speed;
          st_nxt.high = !dev_low_speed && dev_high_speed;
        end
      end
      hps_pkg::PS_ENA:
      begin
        if (set_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_SUSPEND))
          st_nxt.ps = hps_pkg::PS_SUSP;
        else if (set_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_RESET))
        begin
          st_nxt.ps  = hps_pkg::PS_RESET;
          st_nxt.cnt = CW'(RESET_CYC - 1);
        end
      end
      hps_pkg::PS_SUSP:
      begin
        if (resume_det || clr_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_SUSPEND))
        begin
          st_nxt.ps  = hps_pkg::PS_RESUME;
          st_nxt.cnt = CW'(RESUME_CYC - 1);
        end
      end
      hps_pkg::PS_RESUME:
      begin
        if (st_r.cnt == '0)
          st_nxt.ps = hps_pkg::PS_ENA;
      end
      default:
        st_nxt.ps = hps_pkg::PS_OFF;
    endcase
    // Faults and disables override the normal path, the most severe last.
    if (hps_pkg::is_enabled(st_r.ps) && (port_error
        || clr_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_ENABLE)))
      st_nxt.ps = hps_pkg::PS_DISAB;
    if (hps_pkg::is_attached(st_r.ps) && detach_det)
      st_nxt.ps = hps_pkg::PS_DISC;
    // Power loss also beats a power-up requested in the same cycle.
    if (over_current || clr_req(feat_valid, feat_set, feat_sel, hps_pkg::FEAT_POWER))
      st_nxt.ps = hps_pkg::PS_OFF;
    if (feat_valid && feat_sel == hps_pkg::FEAT_TEST)
    begin
      // Test mode may only be entered from a quiet port.
      if (!feat_set)
        st_nxt.test = 1'b0;
      else if (st_r.ps == hps_pkg::PS_DISAB || st_r.ps == hps_pkg::PS_DISC
               || st_r.ps == hps_pkg::PS_SUSP)
        st_nxt.test = 1'b1;
      else
        st_nxt.err = 1'b1;
    end
    if (feat_valid && feat_sel == hps_pkg::FEAT_IND)
      st_nxt.ind = feat_set;
    if (feat_valid && feat_set && feat_sel == hps_pkg::FEAT_ENABLE)
      st_nxt.err = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_r    <= '0;
      st_r.ps <= hps_pkg::PS_OFF;
    end
    else
      st_r <= st_nxt;
  end

  // The word is built from registered state, except bit 3, which follows over_current directly.
  always_comb
  begin
    status_w                    = hps_pkg::STATUS_RESET;
    status_w[hps_pkg::BIT_CONN] = hps_pkg::is_attached(st_r.ps);
    status_w[hps_pkg::BIT_ENA]  = hps_pkg::is_enabled(st_r.ps);
    status_w[hps_pkg::BIT_SUSP] = (st_r.ps == hps_pkg::PS_SUSP)
                               || (st_r.ps == hps_pkg::PS_RESUME);
    status_w[hps_pkg::BIT_OC]   = OC_PER_PORT && over_current;
    status_w[hps_pkg::BIT_RST]  = (st_r.ps == hps_pkg::PS_RESET);
    status_w[hps_pkg::BIT_PWR]  = (st_r.ps != hps_pkg::PS_OFF);
    status_w[hps_pkg::BIT_LOW]  = status_w[hps_pkg::BIT_ENA] && st_r.low;
    status_w[hps_pkg::BIT_HIGH] = status_w[hps_pkg::BIT_ENA] && st_r.high;
    status_w[hps_pkg::BIT_TEST] = st_r.test;
    status_w[hps_pkg::BIT_IND]  = st_r.ind;
  end

  // Status goes first, change second, each low byte first.
  hps_byte_tx u_tx
  (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .load       (tx_load),
    .word       ({port_change, status_w}),
    .tx_data    (tx_data),
    .tx_valid   (tx_valid),
    .tx_ready   (tx_ready)
  );

  assign port_status = status_w;
  assign req_error   = st_r.err;
  assign traffic_fwd = (st_r.ps == hps_pkg::PS_ENA);
  assign reset_sig   = (st_r.ps == hps_pkg::PS_RESET);
  assign resume_sig  = (st_r.ps == hps_pkg::PS_RESUME);
  assign power_on    = status_w[hps_pkg::BIT_PWR];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_reset_req;
    st_r.ps == hps_pkg::PS_DISAB && feat_valid && feat_set
      && feat_sel == hps_pkg::FEAT_RESET && !detach_det && !over_current
      && !(feat_sel == hps_pkg::FEAT_POWER);
  endsequence

  sequence s_reset_held;
    (port_status[hps_pkg::BIT_RST] && reset_sig) [*4];
  endsequence

  sequence s_resume_seen;
    st_r.ps == hps_pkg::PS_SUSP && resume_det && !detach_det && !over_current
      && !port_error && !feat_valid;
  endsequence

  a_conn_forced: assert property (
    (st_r.ps == hps_pkg::PS_OFF || st_r.ps == hps_pkg::PS_DISC)
      |-> !port_status[hps_pkg::BIT_CONN] && !port_status[hps_pkg::BIT_ENA])
    else $error("Connection or enable shown on an empty port.");

  a_enable_source: assert property (
    $rose(port_status[hps_pkg::BIT_ENA])
      |-> $past(st_r.ps) == hps_pkg::PS_RESET && $past(st_r.cnt) == '0)
    else $error("Port enabled without a completed reset.");

  a_fault_disable: assert property (
    port_status[hps_pkg::BIT_ENA] && (port_error || detach_det)
      |=> !port_status[hps_pkg::BIT_ENA] && !port_status[hps_pkg::BIT_SUSP])
    else $error("Port stayed enabled after a fault.");

  a_susp_no_fwd: assert property (
    port_status[hps_pkg::BIT_SUSP] |-> !traffic_fwd)
    else $error("Traffic forwarded to a suspended port.");

  a_resume_keeps: assert property (
    s_resume_seen |=> port_status[hps_pkg::BIT_SUSP] && resume_sig)
    else $error("Resume did not keep the suspend bit while resuming.");

  a_resume_end: assert property (
    st_r.ps == hps_pkg::PS_RESUME && st_r.cnt == '0 && !port_error
      && !detach_det && !over_current && !feat_valid
      |=> !port_status[hps_pkg::BIT_SUSP] && traffic_fwd)
    else $error("Suspend bit not cleared after resume.");

  a_oc_power_off: assert property (
    OC_PER_PORT && over_current |-> port_status[hps_pkg::BIT_OC]
      ##1 !port_status[hps_pkg::BIT_PWR])
    else $error("Over-current not reported or power not removed.");

  a_reset_hold: assert property (
    s_reset_req |=> s_reset_held)
    else $error("Reset bit dropped before the reset time.");

  a_reserved_zero: assert property (
    port_status[7:5] == 3'h0 && port_status[15:13] == 3'h0)
    else $error("Reserved status bits not zero.");

  a_speed_excl: assert property (
    port_status[hps_pkg::BIT_LOW] |-> !port_status[hps_pkg::BIT_HIGH]
      && port_status[hps_pkg::BIT_CONN])
    else $error("Low and high speed shown together or without device.");

  a_test_source: assert property (
    $changed(port_status[hps_pkg::BIT_TEST])
      |-> $past(feat_valid) && $past(feat_sel) == hps_pkg::FEAT_TEST)
    else $error("Test mode changed without a feature request.");

  a_ind_source: assert property (
    $changed(port_status[hps_pkg::BIT_IND])
      |-> $past(feat_valid) && $past(feat_sel) == hps_pkg::FEAT_IND)
    else $error("Indicator control changed without a feature request.");

  a_snapshot: assert property (
    tx_load |=> tx_valid && tx_data == $past(port_status[7:0]))
    else $error("First answer byte is not the captured status low byte.");

  a_bad_request: assert property (
    setup_valid && !get_ok |=> req_error && !$rose(tx_valid))
    else $error("Malformed get-status request not refused.");
endmodule // hps_port_status

// >>> hw/hps_rst_sync.sv
// Purpose: Releases the asynchronous reset through two flip-flops.
// Assumes: Assertion may be asynchronous, release is made synchronous.
// Notes:   Only the second stage is used downstream.
`timescale 1ns/100ps
module hps_rst_sync
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Synchronised reset
  output logic      rst_sync_n
);
  logic [1:0] sync_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sync_r <= 2'h0;
    else
      sync_r <= {sync_r[0], 1'b1};
  end

  assign rst_sync_n = sync_r[1];
endmodule // hps_rst_sync

// >>> tb/hps_host_model.sv
// Purpose: Host software side: issues port get-status requests, takes answer bytes.
// Assumes: Fields change at falling edges; the device samples at rising edges.
// Notes:   Released setup fields show the inverse of the request so stale data never helps.
`timescale 1ns/100ps
module hps_host_model
(
  // Clock
  input  wire logic        clk_sys,
  // Setup stage
  output logic             setup_valid,
  output logic [7:0]       req_type,
  output logic [7:0]       req_code,
  output logic [15:0]      req_value,
  output logic [15:0]      req_index,
  output logic [15:0]      req_length,
  input  wire logic        req_error,
  // Data stage
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready
);
  initial
  begin
    setup_valid = 1'b0;
    tx_ready = 1'b0;
    {req_type, req_code, req_value, req_index, req_length} = '1;
  end

  // A set stall bit holds off the byte taken in that cycle.
  task automatic get_status(input logic [7:0] rt, input logic [15:0] rv, input logic [15:0] ri,
                            input logic [15:0] rl, input logic [31:0] stall,
                            output logic [31:0] w, output logic err);
    int i;
    int n;
    n = 0;
    w = 32'h0000_0000;
    @(negedge clk_sys);
    setup_valid = 1'b1;
    req_type = rt;
    req_code = hps_pkg::GET_STATUS_CODE;
    req_value = rv;
    req_index = ri;
    req_length = rl;
    @(negedge clk_sys);
    setup_valid = 1'b0;
    {req_type, req_code, req_value, req_index, req_length} =
      ~{req_type, req_code, req_value, req_index, req_length};
    err = req_error;
    for (i = 0; i < 200 && n < 4 && err === 1'b0; i++)
    begin
      @(negedge clk_sys);
      tx_ready = ~stall[i % 32];
      // The byte stands from this edge until the rising edge that takes it.
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
        w[8*n +: 8] = tx_data;
        n++;
      end
      @(posedge clk_sys);
    end
    // An answer that never completes is reported as a failed request.
    if (err === 1'b0 && n < 4)
      err = 1'b1;
    @(negedge clk_sys);
    tx_ready = 1'b0;
  endtask
endmodule // hps_host_model

// >>> tb/hub_port_status_word_tb.sv
// Purpose: Self-checking bench of the port status word against a bench-side model.
// Assumes: Short reset and resume counts so a run stays brief.
// Notes:   Three attach passes cover low, high and full speed devices.
`timescale 1ns/100ps
module hub_port_status_word_tb;
  logic                  clk_sys, rst_n, setup_valid, req_error, feat_valid, feat_set;
  logic                  attach_det, detach_det, port_error, resume_det, over_current;
  logic                  dev_low_speed, dev_high_speed, tx_valid, tx_ready;
  logic                  traffic_fwd, reset_sig, resume_sig, power_on, err;
  logic [7:0]            req_type, req_code, tx_data;
  logic [15:0]           req_value, req_index, req_length, port_change, port_status, exp;
  logic [31:0]           lfsr_q, word;
  hps_pkg::hps_feat_type feat_sel;
  int                    error_cnt, n_checks;
  logic [7:0]            byte_q [$];
  // Bad requests: type, value, index, length.
  logic [55:0] bad [5] = '{{8'hA0, 16'h0000, 16'h0001, 16'h0004},
                           {8'hA3, 16'h0001, 16'h0001, 16'h0004},
                           {8'hA3, 16'h0000, 16'h0000, 16'h0004},
                           {8'hA3, 16'h0000, 16'h0002, 16'h0004},
                           {8'hA3, 16'h0000, 16'h0001, 16'h0002}};

  hps_port_status #(.RESET_CYC(10), .RESUME_CYC(12)) DUT
  (
    .clk_sys, .rst_n, .setup_valid, .req_type, .req_code, .req_value, .req_index,
    .req_length, .req_error, .feat_valid, .feat_set, .feat_sel, .attach_det, .detach_det,
    .port_error, .resume_det, .over_current, .dev_low_speed, .dev_high_speed, .port_change,
    .tx_data, .tx_valid, .tx_ready, .port_status, .traffic_fwd, .reset_sig, .resume_sig,
    .power_on
  );

  hps_host_model host
  (
    .clk_sys, .setup_valid, .req_type, .req_code, .req_value, .req_index, .req_length,
    .req_error, .tx_data, .tx_valid, .tx_ready
  );

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic feat(input hps_pkg::hps_feat_type s, input logic v);
    @(negedge clk_sys);
    feat_valid = 1'b1;
    feat_set = v;
    feat_sel = s;
    @(negedge clk_sys);
    feat_valid = 1'b0;
  endtask

  // Line events in the order attach, detach, error, resume.
  task automatic ev(input int k);
    @(negedge clk_sys);
    {attach_det, detach_det, port_error, resume_det} = 4'b1000 >> k;
    @(negedge clk_sys);
    {attach_det, detach_det, port_error, resume_det} = 4'b0000;
  endtask

  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 100 && port_status[b] !== v; i++)
      @(negedge clk_sys);
    if (i == 100)
    begin
      error_cnt++;
      $display("Error wait on status bit %0d expected %b seen %b", b, v, port_status[b]);
      tally_and_finish();
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("Error run limit expected end seen none");
    tally_and_finish();
  end

  initial
  begin
    {rst_n, feat_valid, feat_set, attach_det, detach_det, port_error} = '0;
    {resume_det, over_current, dev_low_speed, dev_high_speed} = '0;
    feat_sel = hps_pkg::FEAT_ENABLE;
    port_change = 16'h0000;
    lfsr_q = 32'h0001_68BD;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    exp = 16'h0000;
    chk("status after reset", port_status, exp);
    for (int k = 0; k < 5; k++)
    begin
      host.get_status(bad[k][55:48], bad[k][47:32], bad[k][31:16], bad[k][15:0], 0, word, err);
      chk("bad request refused", err, 1);
    end
    for (int it = 0; it < 3; it++)
    begin
      lfsr_q = nx(lfsr_q);
      feat(hps_pkg::FEAT_POWER, 1'b1);
      exp = 16'h0100;
      chk("powered", port_status, exp);
      chk("power_on", power_on, 1);
      ev(0);
      exp[0] = 1'b1;
      chk("attached", port_status, exp);
      dev_low_speed = (it == 0);
      dev_high_speed = (it != 2);
      feat(hps_pkg::FEAT_RESET, 1'b1);
      exp[4] = 1'b1;
      chk("reset set", port_status, exp);
      chk("reset_sig", reset_sig, 1);
      wait_bit(4, 1'b0);
      exp[4] = 1'b0;
      exp[1] = 1'b1;
      exp[9] = (it == 0);
      exp[10] = (it == 1);
      chk("enabled speed", port_status, exp);
      chk("traffic on", traffic_fwd, 1);
      feat(hps_pkg::FEAT_ENABLE, 1'b1);
      chk("set enable refused", req_error, 1);
      feat(hps_pkg::FEAT_IND, 1'b1);
      exp[12] = 1'b1;
      chk("indicator on", port_status, exp);
      port_change = lfsr_q[15:0];
      fork
        host.get_status(8'hA3, 16'h0000, 16'h0001, 16'h0004, lfsr_q, word, err);
        begin
          repeat (2) @(negedge clk_sys);
          port_change = ~port_change;
        end
      join
      chk("answer taken", err, 0);
      if (err !== 1'b0)
        tally_and_finish();
      byte_q.push_back(exp[7:0]);
      byte_q.push_back(exp[15:8]);
      byte_q.push_back(~port_change[7:0]);
      byte_q.push_back(~port_change[15:8]);
      for (int b = 0; b < 4; b++)
        chk("answer byte", word[8*b +: 8], byte_q.pop_front());
      feat(hps_pkg::FEAT_IND, 1'b0);
      exp[12] = 1'b0;
      chk("indicator off", port_status, exp);
      if (it == 0)
      begin
        ev(2);
        exp = 16'h0101;
        chk("error disables", port_status, exp);
        ev(1);
        exp = 16'h0100;
        chk("detached", port_status, exp);
        feat(hps_pkg::FEAT_POWER, 1'b0);
      end
      else if (it == 1)
      begin
        feat(hps_pkg::FEAT_SUSPEND, 1'b1);
        exp[2] = 1'b1;
        chk("suspended", port_status, exp);
        chk("traffic held", traffic_fwd, 0);
        ev(3);
        chk("resuming", port_status, exp);
        chk("resume_sig", resume_sig, 1);
        wait_bit(2, 1'b0);
        exp[2] = 1'b0;
        chk("resumed", port_status, exp);
        feat(hps_pkg::FEAT_ENABLE, 1'b0);
        exp = 16'h0101;
        chk("host disable", port_status, exp);
        feat(hps_pkg::FEAT_TEST, 1'b1);
        exp[11] = 1'b1;
        chk("test on", port_status, exp);
        feat(hps_pkg::FEAT_TEST, 1'b0);
        exp[11] = 1'b0;
        chk("test off", port_status, exp);
        feat(hps_pkg::FEAT_POWER, 1'b0);
      end
      else
      begin
        feat(hps_pkg::FEAT_SUSPEND, 1'b1);
        feat(hps_pkg::FEAT_SUSPEND, 1'b0);
        chk("host resume", port_status, exp | 16'h0004);
        chk("host resume_sig", resume_sig, 1);
        wait_bit(2, 1'b0);
        chk("host resumed", port_status, exp);
        feat(hps_pkg::FEAT_TEST, 1'b1);
        chk("test refused", req_error, 1);
        chk("test unchanged", port_status, exp);
        @(negedge clk_sys);
        over_current = 1'b1;
        @(negedge clk_sys);
        exp = 16'h0008;
        chk("over-current", port_status, exp);
        over_current = 1'b0;
        @(negedge clk_sys);
      end
      exp = 16'h0000;
      chk("powered off", port_status, exp);
    end
    tally_and_finish();
  end
endmodule // hub_port_status_word_tb
